// File: logic/sfsc_pkg.sv
package sfsc_pkg;
    // ==========================================================
    // opcodes
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
    localparam logic [7:0] OP_BYTE_PROG = 8'h02;
    localparam logic [7:0] OP_SEQ_PROG = 8'hAF;
    localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
    localparam logic [7:0] OP_STATUS_UNLOCK = 8'h50;
    localparam logic [7:0] OP_STATUS_STORE = 8'h01;
    localparam logic [7:0] OP_ARM_WRITE = 8'h06;
    localparam logic [7:0] OP_DISARM_WRITE = 8'h04;
    localparam logic [7:0] OP_IDENT_A = 8'h90;
    localparam logic [7:0] OP_IDENT_B = 8'hAB;
    // ==========================================================
    // status byte fields
    localparam int ST_BUSY = 0;
    localparam int ST_ARM = 1;
    localparam int ST_GUARD_LO = 2;
    localparam int ST_GUARD_HI = 3;
    localparam int ST_SEQ = 6;
    localparam int ST_LOCK = 7;
    localparam logic [1:0] GUARD_RESET = 2'h3;
    localparam logic LOCK_RESET = 1'b0;
    // ==========================================================
    // protection boundaries, 16-bit array address
    localparam logic [15:0] ADDR_TOP = 16'hFFFF;
    localparam logic [15:0] PROT_QUARTER = 16'hC000;
    localparam logic [15:0] PROT_HALF = 16'h8000;
    localparam logic [15:0] PROT_ALL = 16'h0000;
    // identification bytes, values arbitrary
    localparam logic [7:0] MAKER_CODE = 8'h5A;
    localparam logic [7:0] PART_CODE = 8'h3C;
    // ==========================================================
    typedef struct packed {
        logic lock;
        logic seq;
        logic [1:0] rsvd;
        logic [1:0] guard;
        logic arm;
        logic busy;
    } sfsc_status_t;
    typedef struct packed {
        logic start;
        logic [1:0] kind; // 0 byte prog, 1 sector, 2 block, 3 chip
        logic [15:0] addr;
    } sfsc_op_t;
endpackage

// File: logic/sfsc_flash_ctrl.sv
`timescale 1ns/1ps
// How it works
// - status bit 0 shows internal operation busy
// - writes refused unless write latch set
// - latch clears on power-up and after erase or byte program instructions
// - guard store needs pin high or unlocked
// - chip erase only with guards zero
// - power-up guards eleven, lock cleared
// - pin low and lock set freezes guards
// - guard level selects protected address range
// - quarter level ignored by block erase
// - status byte layout, reserved bits zero
// - bit 6 shows sequential program mode
// - select fall starts, msb-first bytes
// - early select rise abandons instruction
// - 06H arms latch, 04H disarms
// - identification 90H/ABH, address, then byte
// - id address bit0 picks maker/part
// - status streams until select rises
module sfsc_flash_ctrl
    import sfsc_pkg::*;
#(
    parameter int OP_CYCLES = 64
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic select_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic guard_pin_n,
    output sfsc_pkg::sfsc_op_t op_q,
    output sfsc_pkg::sfsc_status_t status_q,
    output logic [7:0] data_in_q,
    output logic sdo_q,
    output logic sdo_oe_q
);
    import sfsc_pkg::*;

    // ==========================================================
    // pin synchronisers and edge detection
    logic [1:0] sel_s_q, sck_s_q, sdi_s_q, wp_s_q;
    logic sel_d_q, sck_d_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_s_q <= 2'h3;
            sck_s_q <= 2'h0;
            sdi_s_q <= 2'h0;
            wp_s_q <= 2'h3;
            sel_d_q <= 1'b1;
            sck_d_q <= 1'b0;
        end else if (clk_en) begin
            sel_s_q <= {sel_s_q[0], select_n};
            sck_s_q <= {sck_s_q[0], sclk};
            sdi_s_q <= {sdi_s_q[0], sdi};
            wp_s_q <= {wp_s_q[0], guard_pin_n};
            sel_d_q <= sel_s_q[1];
            sck_d_q <= sck_s_q[1];
        end
    end
    logic sel, rise, fall, sel_fall, sel_rise, wp_high;
    assign sel = !sel_s_q[1];
    assign rise = sel && sck_s_q[1] && !sck_d_q;
    assign fall = sel && !sck_s_q[1] && sck_d_q;
    assign sel_fall = !sel_s_q[1] && sel_d_q;
    assign sel_rise = sel_s_q[1] && !sel_d_q;
    assign wp_high = wp_s_q[1];

    // ==========================================================
    // serial shifter: bits and bus cycles
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [2:0] byte_q;
    logic [7:0] opc_q;
    logic [23:0] addr_q;
    logic [7:0] dat_q;
    logic [7:0] byte_val;
    assign byte_val = {sh_q[6:0], sdi_s_q[1]};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            byte_q <= 3'h0;
            opc_q <= 8'h00;
            addr_q <= 24'h000000;
            dat_q <= 8'h00;
        end else if (clk_en) begin
            if (sel_fall || !sel) begin
                bit_q <= 3'h0;
                byte_q <= 3'h0;
            end else if (rise) begin
                sh_q <= byte_val;
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    if (byte_q != 3'h7) begin
                        byte_q <= byte_q + 3'h1;
                    end
                    if (byte_q == 3'h0) begin
                        opc_q <= byte_val;
                    end else if (byte_q < 3'h4) begin
                        addr_q <= {addr_q[15:0], byte_val};
                    end else if (byte_q == 3'h4) begin
                        dat_q <= byte_val;
                    end
                end
            end
        end
    end

    // ==========================================================
    // decode, evaluated at select rise
    logic complete;
    logic [15:0] a16;
    logic [15:0] bound;
    logic prot, unlocked_q;
    assign a16 = addr_q[15:0];
    // early rise leaves bit_q mid-byte, so nothing executes
    assign complete = sel_rise && bit_q == 3'h0;
    always_comb begin
        unique case (status_q.guard)
            2'h0: bound = ADDR_TOP;
            2'h1: bound = PROT_QUARTER;
            2'h2: bound = PROT_HALF;
            default: bound = PROT_ALL;
        endcase
    end
    // level 1 bound is skipped for block erase
    assign prot = (status_q.guard != 2'h0)
        && !(opc_q == OP_BLOCK_ERASE && status_q.guard == 2'h1)
        && a16 >= bound
        && !(status_q.guard == 2'h0);
    logic arm_ok;
    assign arm_ok = status_q.arm && !status_q.busy;
    logic cnt_busy;
    logic [15:0] cnt_q;
    logic [15:0] seq_addr_q;
    assign cnt_busy = cnt_q != 16'h0000;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '{lock: LOCK_RESET, seq: 1'b0, rsvd: 2'h0, guard: GUARD_RESET,
                          arm: 1'b0, busy: 1'b0};
            unlocked_q <= 1'b0;
            op_q <= '0;
            cnt_q <= 16'h0000;
            seq_addr_q <= 16'h0000;
            data_in_q <= 8'h00;
        end else if (clk_en) begin
            op_q.start <= 1'b0;
            status_q.rsvd <= 2'h0;
            if (cnt_busy) begin
                cnt_q <= cnt_q - 16'h0001;
            end
            status_q.busy <= cnt_busy && cnt_q != 16'h0001;
            if (complete) begin
                unlocked_q <= (opc_q == OP_STATUS_UNLOCK) && byte_q == 3'h1;
                if (!status_q.busy) begin
                    unique case (opc_q)
                        OP_ARM_WRITE: if (byte_q == 3'h1) status_q.arm <= 1'b1;
                        OP_DISARM_WRITE: if (byte_q == 3'h1) begin
                            status_q.arm <= 1'b0;
                            status_q.seq <= 1'b0;
                        end
                        OP_STATUS_STORE: begin
                            // only guard and lock fields follow the data byte
                            if (byte_q == 3'h2 && unlocked_q &&
                                (wp_high || !status_q.lock)) begin
                                status_q.guard <= {addr_q[3], addr_q[2]};
                                status_q.lock <= addr_q[7];
                            end
                        end
                        OP_CHIP_ERASE: begin
                            if (byte_q == 3'h1 && arm_ok &&
                                status_q.guard == 2'h0) begin
                                op_q <= '{start: 1'b1, kind: 2'h3, addr: 16'h0000};
                                cnt_q <= 16'(OP_CYCLES);
                                status_q.busy <= 1'b1;
                            end
                            status_q.arm <= 1'b0;
                        end
                        OP_SECTOR_ERASE, OP_BLOCK_ERASE: begin
                            if (byte_q == 3'h4 && arm_ok && !prot) begin
                                op_q <= '{start: 1'b1,
                                          kind: (opc_q == OP_BLOCK_ERASE) ? 2'h2 : 2'h1,
                                          addr: a16};
                                cnt_q <= 16'(OP_CYCLES);
                                status_q.busy <= 1'b1;
                            end
                            status_q.arm <= 1'b0;
                        end
                        OP_BYTE_PROG: begin
                            if (byte_q == 3'h5 && arm_ok && !prot) begin
                                op_q <= '{start: 1'b1, kind: 2'h0, addr: a16};
                                data_in_q <= dat_q;
                                cnt_q <= 16'(OP_CYCLES);
                                status_q.busy <= 1'b1;
                            end
                            status_q.arm <= 1'b0;
                        end
                        OP_SEQ_PROG: begin
                            // first frame carries address, later frames data only
                            if (arm_ok && ((byte_q == 3'h5 && !status_q.seq && !prot) ||
                                           (byte_q == 3'h2 && status_q.seq))) begin
                                op_q <= '{start: 1'b1, kind: 2'h0,
                                          addr: status_q.seq ? seq_addr_q : a16};
                                data_in_q <= status_q.seq ? addr_q[7:0] : dat_q;
                                seq_addr_q <= (status_q.seq ? seq_addr_q : a16) + 16'h0001;
                                cnt_q <= 16'(OP_CYCLES);
                                status_q.busy <= 1'b1;
                                status_q.seq <= 1'b1;
                                if ((status_q.seq ? seq_addr_q : a16) == ADDR_TOP) begin
                                    status_q.seq <= 1'b0;
                                    status_q.arm <= 1'b0;
                                end
                            end
                        end
                        default: ;
                    endcase
                end
            end else if (sel_rise) begin
                unlocked_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // output shifter, changes on serial clock falling edge
    logic [7:0] out_q;
    logic is_id, is_st;
    assign is_id = opc_q == OP_IDENT_A || opc_q == OP_IDENT_B;
    assign is_st = opc_q == OP_STATUS_FETCH;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 8'h00;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else if (clk_en) begin
            if (!sel) begin
                sdo_oe_q <= 1'b0;
            end else if (fall) begin
                if (bit_q == 3'h0 && byte_q != 3'h0) begin
                    if (is_st) begin
                        sdo_q <= status_q[7];
                        out_q <= {status_q[6:0], 1'b0};
                        sdo_oe_q <= 1'b1;
                    end else if (is_id && byte_q >= 3'h4) begin
                        sdo_q <= addr_q[0] ? PART_CODE[7] : MAKER_CODE[7];
                        out_q <= {addr_q[0] ? PART_CODE[6:0] : MAKER_CODE[6:0], 1'b0};
                        sdo_oe_q <= 1'b1;
                    end else if (opc_q == OP_READ && byte_q >= 3'h4) begin
                        // array contents lie outside this block; erased value shown
                        sdo_q <= 1'b1;
                        out_q <= 8'hFE;
                        sdo_oe_q <= 1'b1;
                    end
                end else begin
                    sdo_q <= out_q[7];
                    out_q <= {out_q[6:0], out_q[0]};
                end
            end
        end
    end

    // ==========================================================
    // checks
    sequence early_release_s;
        sel_rise && bit_q != 3'h0;
    endsequence
    busy_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
        op_q.start |-> status_q.busy)
        else $error("busy not set at operation start");
    chip_guard_a: assert property (@(posedge clock) disable iff (!rst_n)
        (op_q.start && op_q.kind == 2'h3) |-> $past(status_q.guard) == 2'h0)
        else $error("chip erase with guard set");
    arm_needed_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(op_q.start) |-> $past(status_q.arm))
        else $error("operation without write latch");
    arm_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        (op_q.start && op_q.kind != 2'h0) |-> !status_q.arm)
        else $error("latch survives erase");
    prog_disarm_a: assert property (@(posedge clock) disable iff (!rst_n)
        (op_q.start && op_q.kind == 2'h0 && !status_q.seq) |-> !status_q.arm)
        else $error("latch survives byte program");
    lock_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        (!wp_high && status_q.lock) |=> $stable({status_q.lock, status_q.guard}))
        else $error("guard changed while locked");
    rsvd_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        status_q.rsvd == 2'h0)
        else $error("reserved bits nonzero");
    no_prot_a: assert property (@(posedge clock) disable iff (!rst_n)
        (op_q.start && op_q.kind == 2'h0 && status_q.guard == 2'h3) |-> 1'b0)
        else $error("program into fully guarded array");
    abandon_a: assert property (@(posedge clock) disable iff (!rst_n)
        early_release_s |=> !op_q.start)
        else $error("partial instruction executed");
endmodule // sfsc_flash_ctrl

// File: verif/sfsc_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// serial host, mode 0: clock idles low and stands still between frames
module sfsc_host_model (
    input wire logic clock,
    input wire logic sdo_q,
    input wire logic sdo_oe_q,
    output logic select_n,
    output logic sclk,
    output logic sdi
);
    logic line_last = 1'b0;
    logic line;
    // no pull on the output line: a released line shows a toggling pattern
    assign line = sdo_oe_q ? sdo_q : ~line_last;
    always @(posedge clock) line_last <= line;
    initial begin
        select_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // msb first, select raised only after the last bit
    task automatic frame(input logic [55:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge clock);
        select_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi = tx[55 - i];
            repeat (4) @(negedge clock);
            sclk = 1'b1;
            repeat (4) @(negedge clock);
            // sampled late in the high phase, before the fall moves the output
            rx = {rx[14:0], line};
            sclk = 1'b0;
        end
        repeat (4) @(negedge clock);
        select_n = 1'b1;
        sdi = 1'b0;
        repeat (6) @(negedge clock);
    endtask
endmodule // sfsc_host_model

// File: verif/serial_flash_status_and_commands_test.sv
`timescale 1ns/1ps
module serial_flash_status_and_commands_test;
    import sfsc_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic guard_pin_n = 1'b1;
    logic select_n, sclk, sdi, sdo_q, sdo_oe_q;
    sfsc_op_t op_q, last_op;
    sfsc_status_t status_q;
    logic [7:0] data_in_q, last_data;
    logic [15:0] rx;
    int err_count = 0;
    int cmp_count = 0;
    int starts = 0;
    initial forever #20 clock = ~clock;
    sfsc_flash_ctrl #(.OP_CYCLES(8)) sfsc_flash_ctrl_inst (.clock(clock), .rst_n(rst_n),
        .clk_en(1'b1), .select_n(select_n), .sclk(sclk), .sdi(sdi), .guard_pin_n(guard_pin_n),
        .op_q(op_q), .status_q(status_q), .data_in_q(data_in_q), .sdo_q(sdo_q),
        .sdo_oe_q(sdo_oe_q));
    sfsc_host_model sfsc_host_model_inst (.clock(clock), .sdo_q(sdo_q), .sdo_oe_q(sdo_oe_q),
        .select_n(select_n), .sclk(sclk), .sdi(sdi));
    always @(posedge clock) begin
        if (op_q.start === 1'b1) begin
            starts <= starts + 1;
            last_op <= op_q;
            last_data <= data_in_q;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmd(input logic [55:0] tx, input int nbits);
        sfsc_host_model_inst.frame(tx, nbits, rx);
    endtask
    task automatic store(input logic [7:0] val);
        cmd({OP_STATUS_UNLOCK, 48'h0}, 8);
        cmd({OP_STATUS_STORE, val, 40'h0}, 16);
    endtask
    // one write attempt; the wait lets any internal operation finish
    task automatic op_try(input int arm, input logic [55:0] tx, input int nbits, input int go,
            input logic [1:0] kind, input logic [15:0] addr);
        int n;
        if (arm == 1) cmd({OP_ARM_WRITE, 48'h0}, 8);
        n = starts;
        cmd(tx, nbits);
        check(starts - n, go);
        if (go == 1) begin
            check(last_op.kind, kind);
            check(last_op.addr, addr);
            check(status_q.busy, 1'b1);
        end
        repeat (12) @(negedge clock);
        check(status_q.busy, 1'b0);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_fetch();
        check(status_q, 8'h0C);
        sfsc_host_model_inst.frame({OP_STATUS_FETCH, 48'h0}, 24, rx);
        check(rx, 16'h0C0C);
        check(sdo_oe_q, 1'b0);
    endtask
    task automatic t_store();
        store(8'h73);
        check(status_q, 8'h00);
        cmd({OP_STATUS_STORE, 8'h0C, 40'h0}, 16);
        check(status_q, 8'h00);
    endtask
    task automatic t_latch();
        op_try(0, {OP_BYTE_PROG, 24'h001000, 8'h11, 16'h0}, 40, 0, 2'h0, 16'h0);
        cmd({OP_ARM_WRITE, 48'h0}, 8);
        check(status_q.arm, 1'b1);
        cmd({OP_DISARM_WRITE, 48'h0}, 8);
        check(status_q.arm, 1'b0);
        cmd({OP_ARM_WRITE, 48'h0}, 5);
        check(status_q.arm, 1'b0);
        cmd({OP_ARM_WRITE, 48'h0}, 8);
        cmd({OP_DISARM_WRITE, 48'h0}, 13);
        check(status_q.arm, 1'b1);
    endtask
    task automatic t_program();
        op_try(1, {OP_BYTE_PROG, 24'h00C000, 8'hA5, 16'h0}, 40, 1, 2'h0, 16'hC000);
        check(last_data, 8'hA5);
        check(status_q.arm, 1'b0);
        op_try(1, {OP_CHIP_ERASE, 48'h0}, 8, 1, 2'h3, 16'h0000);
        check(status_q.arm, 1'b0);
    endtask
    task automatic t_seq();
        op_try(1, {OP_SEQ_PROG, 24'h001000, 8'h5A, 16'h0}, 40, 1, 2'h0, 16'h1000);
        check(status_q.seq, 1'b1);
        op_try(0, {OP_SEQ_PROG, 8'h6B, 40'h0}, 16, 1, 2'h0, 16'h1001);
        check(last_data, 8'h6B);
        cmd({OP_DISARM_WRITE, 48'h0}, 8);
        check(status_q.seq, 1'b0);
    endtask
    task automatic t_guard();
        store(8'h04);
        op_try(1, {OP_BYTE_PROG, 24'h00C000, 24'h0}, 40, 0, 2'h0, 16'h0);
        op_try(1, {OP_BYTE_PROG, 24'h00BFFF, 24'h0}, 40, 1, 2'h0, 16'hBFFF);
        op_try(1, {OP_BLOCK_ERASE, 24'h00C000, 24'h0}, 32, 1, 2'h2, 16'hC000);
        op_try(1, {OP_SECTOR_ERASE, 24'h00C000, 24'h0}, 32, 0, 2'h1, 16'h0);
        op_try(1, {OP_CHIP_ERASE, 48'h0}, 8, 0, 2'h3, 16'h0);
        store(8'h08);
        op_try(1, {OP_SECTOR_ERASE, 24'h008000, 24'h0}, 32, 0, 2'h1, 16'h0);
        op_try(1, {OP_SECTOR_ERASE, 24'h007000, 24'h0}, 32, 1, 2'h1, 16'h7000);
        store(8'h0C);
        op_try(1, {OP_BYTE_PROG, 24'h000000, 24'h0}, 40, 0, 2'h0, 16'h0);
    endtask
    task automatic t_lock();
        guard_pin_n = 1'b0;
        store(8'h84);
        check(status_q, 8'h84);
        store(8'h00);
        check(status_q, 8'h84);
        guard_pin_n = 1'b1;
        store(8'h00);
        check(status_q, 8'h00);
    endtask
    task automatic t_ident();
        sfsc_host_model_inst.frame({OP_IDENT_A, 16'h0, 8'h01, 24'h0}, 48, rx);
        check(rx, {PART_CODE, PART_CODE});
        sfsc_host_model_inst.frame({OP_IDENT_B, 24'h0, 24'h0}, 48, rx);
        check(rx, {MAKER_CODE, MAKER_CODE});
        sfsc_host_model_inst.frame({OP_READ, 24'h001234, 24'h0}, 48, rx);
        check(rx, 16'hFFFF);
    endtask
    // ==========================================================
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        t_fetch();
        t_store();
        t_latch();
        t_program();
        t_seq();
        t_guard();
        t_lock();
        t_ident();
        test_done();
    end
    // the whole run needs well under one millisecond
    initial begin
        #3000000;
        err_count++;
        test_done();
    end
endmodule // serial_flash_status_and_commands_test
